// ===== rtl/cdrp_direct_port.sv
// codec direct register port: index, indexed data, status and pio data
`timescale 1ns/1ns
module cdrp_direct_port (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [1:0] I_ADDR,
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  input wire logic I_MODE_EXT,
  input wire logic [1:0] I_PM_FIELD,
  input wire logic I_PB_IRQ_EVENT,
  input wire logic I_CAP_IRQ_EVENT,
  input wire logic I_UNDERRUN,
  input wire logic I_OVERRUN,
  input wire logic I_PB_DRQ_REQ,
  input wire logic I_CAP_DRQ_REQ,
  output logic O_PB_DRQ,
  output logic O_CAP_DRQ,
  output logic O_IRQ,
  output logic O_DAC_MUTE,
  output logic O_PB_ENABLE,
  output logic O_CAP_ENABLE,
  input wire logic [7:0] I_DAC_RATE_CODE,
  output logic [11:0] O_DAC_DIVIDER,
  output logic [31:0] O_PB_SAMPLE,
  output logic O_PB_SAMPLE_VALID,
  input wire logic I_PB_TAKE,
  input wire logic [31:0] I_CAP_SAMPLE,
  input wire logic I_CAP_SAMPLE_VALID
);

  cdrp_pkg::cdrp_state_s st;
  cdrp_pkg::cdrp_state_s next_st;
  logic [7:0] mem_q;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [4:0] eff_idx;
  logic blocked;
  logic [7:0] status_byte;
  logic [7:0] index_byte;
  logic [1:0] pb_flags;
  logic [1:0] cap_flags;
  logic st_wr;
  logic st_rd;

  //==========================================================================
  // decoding helpers
  //==========================================================================
  // last tracker position of a sample for a given format byte
  function automatic cdrp_pkg::cdrp_pos_e last_pos(input logic [7:0] fmt);
    logic adpcm;
    logic w16;
    adpcm = fmt[cdrp_pkg::FMT_F1] & ~fmt[cdrp_pkg::FMT_F0] & fmt[cdrp_pkg::FMT_CL];
    w16 = fmt[cdrp_pkg::FMT_F0] & ~fmt[cdrp_pkg::FMT_CL];
    if (adpcm || (w16 && fmt[cdrp_pkg::FMT_STEREO])) begin
      last_pos = cdrp_pkg::POS_B3;
    end else if (w16 || fmt[cdrp_pkg::FMT_STEREO]) begin
      last_pos = cdrp_pkg::POS_B1;
    end else begin
      last_pos = cdrp_pkg::POS_B0;
    end
  endfunction : last_pos

  // side and half flags {side, half} of the byte at a position
  function automatic logic [1:0] pos_flags(input cdrp_pkg::cdrp_pos_e pos, input logic [7:0] fmt);
    logic adpcm;
    logic w16;
    logic first_pair;
    logic odd;
    adpcm = fmt[cdrp_pkg::FMT_F1] & ~fmt[cdrp_pkg::FMT_F0] & fmt[cdrp_pkg::FMT_CL];
    w16 = fmt[cdrp_pkg::FMT_F0] & ~fmt[cdrp_pkg::FMT_CL];
    first_pair = pos[0] | pos[1];
    odd = pos[1] | pos[3];
    if (adpcm) begin
      pos_flags = {first_pair, odd};
    end else if (w16) begin
      // big endian sends the upper byte first
      pos_flags = {first_pair | ~fmt[cdrp_pkg::FMT_STEREO], odd ^ fmt[cdrp_pkg::FMT_F1]};
    end else begin
      pos_flags = {pos[0] | ~fmt[cdrp_pkg::FMT_STEREO], 1'b1};
    end
  endfunction : pos_flags

  // byte lane of a one-hot position
  function automatic logic [1:0] pos_lane(input cdrp_pkg::cdrp_pos_e pos);
    pos_lane = {pos[2] | pos[3], pos[1] | pos[3]};
  endfunction : pos_lane

  // dac divider from the 8-bit rate code
  function automatic logic [11:0] dac_div(input logic [7:0] code);
    unique case (code)
      8'h00: dac_div = cdrp_pkg::DIV_0;
      8'h01: dac_div = cdrp_pkg::DIV_1;
      8'h02: dac_div = cdrp_pkg::DIV_2;
      8'h03: dac_div = cdrp_pkg::DIV_3;
      8'h04: dac_div = cdrp_pkg::DIV_4;
      8'h05: dac_div = cdrp_pkg::DIV_5;
      8'h06: dac_div = cdrp_pkg::DIV_6;
      8'h07: dac_div = cdrp_pkg::DIV_7;
      default: dac_div = (code < cdrp_pkg::RATE_LINEAR_FROM) ? cdrp_pkg::DIV_0 : {code, 4'h0};
    endcase
  endfunction : dac_div

  //==========================================================================
  // indirect register store
  //==========================================================================
  cdrp_ireg_mem u_mem (
    .i_clk(I_CLK),
    .i_we(mem_we),
    .i_addr(eff_idx),
    .i_wdata(mem_wdata),
    .o_rdata(mem_q)
  );

  //==========================================================================
  // visible bytes
  //==========================================================================
  // selected register, upper bank hidden in mode one
  assign eff_idx = I_MODE_EXT ? {st.bank, st.idx} : {1'b0, st.idx};
  assign blocked = (st.init_cnt != 16'h0000) || (I_PM_FIELD == cdrp_pkg::PM_SOFT_DOWN);
  assign index_byte = blocked ? cdrp_pkg::BLOCKED_VALUE : {1'b0, st.mode_change_enable, st.transfer_request_disable, st.bank, st.idx};
  assign pb_flags = pos_flags(st.pb_pos, st.pb_fmt);
  assign cap_flags = pos_flags(st.cap_pos, st.cap_fmt);
  assign st_wr = I_WR && (I_ADDR == cdrp_pkg::OFS_STATUS);
  assign st_rd = I_RD && (I_ADDR == cdrp_pkg::OFS_STATUS);

  // status register assembly
  always_comb begin
    status_byte = 8'h00;
    status_byte[cdrp_pkg::ST_INT] = st.pb_int | st.cap_int;
    status_byte[cdrp_pkg::ST_PLAYBACK_READY] = ~st.pb_full;
    status_byte[cdrp_pkg::ST_PSIDE] = pb_flags[1];
    status_byte[cdrp_pkg::ST_PHALF] = pb_flags[0];
    status_byte[cdrp_pkg::ST_SER] = st.sample_error;
    status_byte[cdrp_pkg::ST_CAPTURE_READY] = st.cap_fresh;
    status_byte[cdrp_pkg::ST_CSIDE] = cap_flags[1];
    status_byte[cdrp_pkg::ST_CHALF] = cap_flags[0];
  end

  //==========================================================================
  // next state
  //==========================================================================
  always_comb begin
    next_st = st;
    mem_we = 1'b0;
    mem_wdata = I_WDATA;
    next_st.rvalid = 1'b0;
    next_st.dac_div = dac_div(I_DAC_RATE_CODE);
    if (st.init_cnt != 16'h0000) begin
      next_st.init_cnt = st.init_cnt - 16'h0001;
    end

    // interrupt and error flags, a set wins over the clear
    next_st.pb_int = (st.pb_int & ~st_wr) | I_PB_IRQ_EVENT;
    next_st.cap_int = (st.cap_int & ~st_wr) | I_CAP_IRQ_EVENT;
    next_st.sample_error = (st.sample_error & ~st_wr) | I_UNDERRUN | I_OVERRUN;

    // host writes
    if (I_WR && !blocked) begin
      unique case (I_ADDR)
        cdrp_pkg::OFS_INDEX: begin
          next_st.mode_change_enable = I_WDATA[cdrp_pkg::IDX_MCE];
          next_st.transfer_request_disable = I_WDATA[cdrp_pkg::IDX_TRD];
          next_st.bank = I_WDATA[cdrp_pkg::IDX_BANK];
          next_st.idx = I_WDATA[3:0];
        end
        cdrp_pkg::OFS_IDATA: begin
          mem_we = 1'b1;
          if (eff_idx == cdrp_pkg::IREG_IFC) begin
            // enable bits always change, the rest only under mode change enable
            if (!st.mode_change_enable) begin
              mem_wdata = {st.ifc[7:2], I_WDATA[cdrp_pkg::IFC_CEN], I_WDATA[cdrp_pkg::IFC_PEN]};
            end
            next_st.ifc = mem_wdata;
          end else if (eff_idx == cdrp_pkg::IREG_PB_FMT) begin
            mem_we = st.mode_change_enable;
            if (st.mode_change_enable) begin
              next_st.pb_fmt = I_WDATA;
            end
          end else if (eff_idx == cdrp_pkg::IREG_CAP_FMT) begin
            mem_we = st.mode_change_enable;
            if (st.mode_change_enable) begin
              next_st.cap_fmt = I_WDATA;
            end
          end else if (eff_idx == cdrp_pkg::IREG_PIN) begin
            next_st.pin = I_WDATA;
          end
        end
        cdrp_pkg::OFS_PIO: begin
          // playback byte into its lane, dropped once the sample is complete
          if (!st.pb_full) begin
            next_st.pb_sample[8*pos_lane(st.pb_pos) +: 8] = I_WDATA;
            if (st.pb_pos == last_pos(st.pb_fmt)) begin
              next_st.pb_full = 1'b1;
            end else begin
              next_st.pb_pos = cdrp_pkg::cdrp_pos_e'({st.pb_pos[2:0], 1'b0});
            end
          end
        end
        default: begin
        end
      endcase
    end

    // playback sample handed off, tracker restarts after status read and send
    if (st.pb_full && I_PB_TAKE) begin
      next_st.pb_sent = 1'b1;
    end
    if (st.pb_full && st_rd) begin
      next_st.pb_sread = 1'b1;
    end
    if (st.pb_full && st.pb_sent && st.pb_sread) begin
      next_st.pb_full = 1'b0;
      next_st.pb_sent = 1'b0;
      next_st.pb_sread = 1'b0;
      next_st.pb_pos = cdrp_pkg::POS_B0;
    end

    // capture sample arrival and restart
    if (I_CAP_SAMPLE_VALID) begin
      next_st.cap_pend = I_CAP_SAMPLE;
      next_st.cap_new = 1'b1;
    end
    if (st_rd) begin
      next_st.cap_sread = 1'b1;
    end
    if (st.cap_new && st.cap_sread) begin
      next_st.cap_buf = st.cap_pend;
      next_st.cap_pos = cdrp_pkg::POS_B0;
      next_st.cap_fresh = 1'b1;
      next_st.cap_new = I_CAP_SAMPLE_VALID;
      next_st.cap_sread = st_rd;
    end

    // host reads: stage one picks the byte, stage two drives it out
    next_st.rd_stage = I_RD;
    next_st.rd_mem = I_RD && (I_ADDR == cdrp_pkg::OFS_IDATA) && !blocked;
    if (I_RD) begin
      unique case (I_ADDR)
        cdrp_pkg::OFS_INDEX: next_st.rd_hold = index_byte;
        cdrp_pkg::OFS_IDATA: next_st.rd_hold = cdrp_pkg::BLOCKED_VALUE;
        cdrp_pkg::OFS_STATUS: next_st.rd_hold = status_byte;
        cdrp_pkg::OFS_PIO: begin
          if (blocked) begin
            next_st.rd_hold = cdrp_pkg::BLOCKED_VALUE;
          end else begin
            next_st.rd_hold = st.cap_buf[8*pos_lane(st.cap_pos) +: 8];
            if (st.cap_fresh) begin
              if (st.cap_pos == last_pos(st.cap_fmt)) begin
                next_st.cap_fresh = 1'b0;
              end else begin
                next_st.cap_pos = cdrp_pkg::cdrp_pos_e'({st.cap_pos[2:0], 1'b0});
              end
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (st.rd_stage) begin
      next_st.rdata = st.rd_mem ? mem_q : st.rd_hold;
      next_st.rvalid = 1'b1;
    end
  end

  // state register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st <= cdrp_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  //==========================================================================
  // outputs
  //==========================================================================
  assign O_RDATA = st.rdata;
  assign O_RVALID = st.rvalid;
  assign O_PB_DRQ = I_PB_DRQ_REQ & ~(st.transfer_request_disable & st.pb_int);
  assign O_CAP_DRQ = I_CAP_DRQ_REQ & ~(st.transfer_request_disable & st.cap_int);
  assign O_IRQ = (st.pb_int | st.cap_int) & st.pin[cdrp_pkg::PIN_IEN];
  assign O_DAC_MUTE = st.mode_change_enable;
  assign O_PB_ENABLE = st.ifc[cdrp_pkg::IFC_PEN];
  assign O_CAP_ENABLE = st.ifc[cdrp_pkg::IFC_CEN];
  assign O_DAC_DIVIDER = st.dac_div;
  assign O_PB_SAMPLE = st.pb_sample;
  assign O_PB_SAMPLE_VALID = st.pb_full;

  //==========================================================================
  // checks
  //==========================================================================
  AST_DIV_FIXED: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_DAC_RATE_CODE == 8'h01) |=> (O_DAC_DIVIDER == cdrp_pkg::DIV_1))
    else $error("rate code one must give divider 353");

  AST_DIV_LINEAR: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_DAC_RATE_CODE == 8'h15) |=> (O_DAC_DIVIDER == cdrp_pkg::DIV_0))
    else $error("rate code 21 must give divider 336");

  AST_DRQ_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st.transfer_request_disable && st.pb_int) |-> !O_PB_DRQ)
    else $error("playback request not held off by interrupt");

  AST_MUTE_OFF: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WR && !blocked && I_ADDR == cdrp_pkg::OFS_INDEX && !I_WDATA[cdrp_pkg::IDX_MCE]) |=> !O_DAC_MUTE)
    else $error("mute stayed after mode change enable cleared");

  AST_BLOCKED_READ: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_RD && blocked && I_ADDR != cdrp_pkg::OFS_STATUS) |-> ##2 (O_RVALID && O_RDATA == 8'h80))
    else $error("blocked read did not return 80h");

  AST_READ_LATENCY: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_RD |-> ##2 O_RVALID)
    else $error("read answer not two cycles after request");

  AST_INT_CLEAR: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st_wr && !I_PB_IRQ_EVENT && !I_CAP_IRQ_EVENT) |=> !(st.pb_int || st.cap_int))
    else $error("status write did not clear interrupt");

  AST_IRQ_PIN: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_IRQ |-> (st.pin[cdrp_pkg::PIN_IEN] && (st.pb_int || st.cap_int)))
    else $error("irq pin active without enable or interrupt");

  AST_PB_DROP: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st.pb_full && I_WR && I_ADDR == cdrp_pkg::OFS_PIO) |=> $stable(O_PB_SAMPLE))
    else $error("write changed a complete playback sample");

  AST_MCE_GUARD: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!st.mode_change_enable && I_WR && I_ADDR == cdrp_pkg::OFS_IDATA && eff_idx == cdrp_pkg::IREG_PB_FMT) |=> $stable(st.pb_fmt))
    else $error("format changed without mode change enable");

endmodule : cdrp_direct_port

// ===== pkg/cdrp_pkg.sv
// package: register map, field positions, reset values and state layout of the codec direct port
//==========================================================================
// Operation
// - dac rate code: 0-7 fixed dividers, 8-21 give 16x21, above that 16 times code
// - four low index bits pick the indirect register behind indexed data
// - fifth index bit reaches indirect 16-31; host writes zero in mode one
// - with transfer disable set, a direction's dma request stops while its interrupt stands
// - format and interface registers need mode change enable, except the two enable bits
// - dac output muted while mode change enable is set
// - init bit reads one while the port cannot answer host cycles
// - after reset and init, index register reads mode change enable set, rest zero
// - during init or soft power down index, data and pio ignore writes, read 80h
// - indexed data reads and writes go to the currently selected indirect register
// - any status write clears the interrupt bit; it reads one while active
// - interrupt pin follows interrupt status only when pin enable bit is set
// - playback ready reads one when a new write is welcome, zero while data valid
// - playback side flag: one for left, mono or first adpcm pair, else zero
// - playback half flag: one for upper, 8-bit, or second and fourth adpcm byte
// - sample error set on capture overrun or playback underrun, source not told
// - capture ready reads one while fresh capture data waits, zero when stale
// - capture side and half flags use the playback encoding, adpcm order too
// - data port writes go to playback data, reads come from capture data
// - capture reads advance tracker, hold on last, restart after status read and sample
// - playback writes advance tracker, extra writes dropped, restart after status read and send
// - indirect registers 16-31 unreachable in mode one
//==========================================================================
package cdrp_pkg;

  // direct register offsets
  localparam logic [1:0] OFS_INDEX = 2'h0;
  localparam logic [1:0] OFS_IDATA = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;
  localparam logic [1:0] OFS_PIO = 2'h3;

  // index register fields
  localparam int IDX_INIT = 7;
  localparam int IDX_MCE = 6;
  localparam int IDX_TRD = 5;
  localparam int IDX_BANK = 4;

  // status register fields
  localparam int ST_INT = 0;
  localparam int ST_PLAYBACK_READY = 1;
  localparam int ST_PSIDE = 2;
  localparam int ST_PHALF = 3;
  localparam int ST_SER = 4;
  localparam int ST_CAPTURE_READY = 5;
  localparam int ST_CSIDE = 6;
  localparam int ST_CHALF = 7;

  // indirect registers the port itself looks at
  localparam logic [4:0] IREG_PB_FMT = 5'h08;
  localparam logic [4:0] IREG_IFC = 5'h09;
  localparam logic [4:0] IREG_PIN = 5'h0A;
  localparam logic [4:0] IREG_CAP_FMT = 5'h1C;
  localparam int IFC_PEN = 0;
  localparam int IFC_CEN = 1;
  localparam int PIN_IEN = 1;
  localparam int FMT_STEREO = 4;
  localparam int FMT_CL = 5;
  localparam int FMT_F0 = 6;
  localparam int FMT_F1 = 7;

  // reset and blocked values
  localparam logic [7:0] BLOCKED_VALUE = 8'h80;
  localparam logic [1:0] PM_SOFT_DOWN = 2'h1;
  localparam logic [15:0] INIT_CYCLES = 16'h0040;

  // dac divider table
  localparam logic [11:0] DIV_0 = 12'h150;
  localparam logic [11:0] DIV_1 = 12'd353;
  localparam logic [11:0] DIV_2 = 12'd529;
  localparam logic [11:0] DIV_3 = 12'd617;
  localparam logic [11:0] DIV_4 = 12'd1058;
  localparam logic [11:0] DIV_5 = 12'd1764;
  localparam logic [11:0] DIV_6 = 12'd2117;
  localparam logic [11:0] DIV_7 = 12'd2558;
  localparam logic [7:0] RATE_LINEAR_FROM = 8'h16;

  // byte tracker positions
  typedef enum logic [3:0] {
    POS_B0 = 4'b0001,
    POS_B1 = 4'b0010,
    POS_B2 = 4'b0100,
    POS_B3 = 4'b1000
  } cdrp_pos_e;

  // whole state of the port
  typedef struct packed {
    logic [15:0] init_cnt;
    logic mode_change_enable;
    logic transfer_request_disable;
    logic bank;
    logic [3:0] idx;
    logic pb_int;
    logic cap_int;
    logic sample_error;
    logic [7:0] pb_fmt;
    logic [7:0] ifc;
    logic [7:0] pin;
    logic [7:0] cap_fmt;
    cdrp_pos_e pb_pos;
    logic pb_full;
    logic pb_sent;
    logic pb_sread;
    logic [31:0] pb_sample;
    cdrp_pos_e cap_pos;
    logic cap_fresh;
    logic cap_new;
    logic cap_sread;
    logic [31:0] cap_buf;
    logic [31:0] cap_pend;
    logic rd_stage;
    logic rd_mem;
    logic [7:0] rd_hold;
    logic [7:0] rdata;
    logic rvalid;
    logic [11:0] dac_div;
  } cdrp_state_s;

  localparam cdrp_state_s STATE_RESET = '{
    init_cnt: INIT_CYCLES, mode_change_enable: 1'b1, pb_pos: POS_B0, cap_pos: POS_B0, default: '0};

endpackage : cdrp_pkg

// ===== rtl/cdrp_ireg_mem.sv
// indirect register store: 32 bytes, one write port, registered read
`timescale 1ns/1ns
module cdrp_ireg_mem (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [0:31];

  //==========================================================================
  // storage
  //==========================================================================
  // read first (a write returns the old byte), read data registered one edge after the address
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule : cdrp_ireg_mem

// ===== verification/cdrp_fifo_model.sv
// fifo side model: takes finished playback samples, delivers capture samples
`timescale 1ns/1ns
module cdrp_fifo_model #(
  parameter int TAKE_DELAY = 5
) (
  input wire logic i_clk,
  input wire logic i_pb_valid,
  output logic o_take,
  output logic [31:0] o_cap,
  output logic o_cap_valid
);
  //==========================================================================
  // playback drain
  // waits a while after a complete sample, then pulses take
  initial begin
    o_take = 1'b0;
    o_cap = 32'h0;
    o_cap_valid = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_pb_valid === 1'b1) begin
        repeat (TAKE_DELAY) @(posedge i_clk);
        o_take <= 1'b1;
        @(posedge i_clk);
        o_take <= 1'b0;
        // one take per sample: wait until the port has restarted its tracker
        while (i_pb_valid === 1'b1) @(posedge i_clk);
      end
    end
  end

  //==========================================================================
  // capture feed
  // one-cycle valid; data is scrambled afterwards so stale values never pass
  task automatic push(input logic [31:0] d);
    @(posedge i_clk);
    o_cap <= d;
    o_cap_valid <= 1'b1;
    @(posedge i_clk);
    o_cap_valid <= 1'b0;
    o_cap <= ~d;
  endtask : push
endmodule : cdrp_fifo_model

// ===== verification/tb_cdrp_direct_port.sv
// self-checking testbench of the codec direct register port
`timescale 1ns/1ns
module tb_cdrp_direct_port;
  logic I_CLK, I_RST, I_RD, I_WR, I_MODE_EXT, I_PB_IRQ_EVENT, I_CAP_IRQ_EVENT;
  logic I_UNDERRUN, I_OVERRUN, I_PB_DRQ_REQ, I_CAP_DRQ_REQ, I_PB_TAKE, I_CAP_SAMPLE_VALID;
  logic O_RVALID, O_PB_DRQ, O_CAP_DRQ, O_IRQ, O_DAC_MUTE, O_PB_ENABLE, O_CAP_ENABLE;
  logic O_PB_SAMPLE_VALID;
  logic [1:0] I_ADDR, I_PM_FIELD;
  logic [7:0] I_WDATA, O_RDATA, I_DAC_RATE_CODE;
  logic [11:0] O_DAC_DIVIDER;
  logic [31:0] O_PB_SAMPLE, I_CAP_SAMPLE, seed, smp;
  logic [15:0] expq[$];
  logic [15:0] q;
  logic [7:0] codes [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h15, 8'h16, 8'h1C, 8'hFF};
  int errors, tests_run;

  cdrp_direct_port DUT (.I_CLK, .I_RST, .I_ADDR, .I_RD, .I_WR, .I_WDATA, .O_RDATA, .O_RVALID,
    .I_MODE_EXT, .I_PM_FIELD, .I_PB_IRQ_EVENT, .I_CAP_IRQ_EVENT, .I_UNDERRUN, .I_OVERRUN,
    .I_PB_DRQ_REQ, .I_CAP_DRQ_REQ, .O_PB_DRQ, .O_CAP_DRQ, .O_IRQ, .O_DAC_MUTE, .O_PB_ENABLE,
    .O_CAP_ENABLE, .I_DAC_RATE_CODE, .O_DAC_DIVIDER, .O_PB_SAMPLE, .O_PB_SAMPLE_VALID,
    .I_PB_TAKE, .I_CAP_SAMPLE, .I_CAP_SAMPLE_VALID);

  cdrp_fifo_model #(.TAKE_DELAY(5)) fifo (.i_clk(I_CLK), .i_pb_valid(O_PB_SAMPLE_VALID),
    .o_take(I_PB_TAKE), .o_cap(I_CAP_SAMPLE), .o_cap_valid(I_CAP_SAMPLE_VALID));

  //==========================================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected dac divider for a rate code
  function automatic logic [11:0] rdiv(input logic [7:0] c);
    logic [11:0] t [8];
    t = '{12'h150, 12'h161, 12'h211, 12'h269, 12'h422, 12'h6E4, 12'h845, 12'h9FE};
    if (c < 8'h08) return t[c[2:0]];
    if (c < 8'h16) return 12'h150;
    return {c, 4'h0};
  endfunction : rdiv

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
  endtask : tick

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask : wr

  // read; the answer is judged by the monitor under mask m
  task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    expq.push_back({m, e});
    @(posedge I_CLK);
    I_RD <= 1'b0;
  endtask : rd

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  //==========================================================================
  // clock, monitor and watchdog
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end

  // every read answer is compared with the oldest note
  always @(posedge I_CLK) begin
    if (O_RVALID === 1'b1) begin
      if (expq.size() == 0) chk("unexpected answer", 32'h0, 32'h1);
      else begin
        q = expq.pop_front();
        chk("read data", {24'h0, q[7:0]}, {24'h0, O_RDATA & q[15:8]});
      end
    end
  end

  initial begin
    tick(20000);
    errors++;
    results();
  end

  //==========================================================================
  // main sequence
  initial begin
    seed = 32'hDEE6895D;
    {I_RD, I_WR, I_PB_IRQ_EVENT, I_CAP_IRQ_EVENT, I_UNDERRUN, I_OVERRUN} = '0;
    {I_PB_DRQ_REQ, I_CAP_DRQ_REQ, I_ADDR, I_PM_FIELD, I_WDATA, I_DAC_RATE_CODE} = '0;
    I_MODE_EXT = 1'b1;
    I_RST = 1'b1;
    tick(4);
    I_RST <= 1'b0;
    rd(0, 8'hFF, 8'h80);
    wr(0, 8'h0F);
    tick(70);
    rd(0, 8'hFF, 8'h40);
    chk("mute", 32'h1, {31'h0, O_DAC_MUTE});
    // formats need mode change enable, enables do not
    wr(0, 8'h48);
    wr(1, 8'h50);
    wr(0, 8'h5C);
    wr(1, 8'h50);
    wr(0, 8'h09);
    wr(1, 8'h03);
    tick(1);
    chk("playback enable", 32'h1, {31'h0, O_PB_ENABLE});
    chk("capture enable", 32'h1, {31'h0, O_CAP_ENABLE});
    chk("mute", 32'h0, {31'h0, O_DAC_MUTE});
    wr(0, 8'h08);
    wr(1, 8'h00);
    rd(1, 8'hFF, 8'h50);
    wr(0, 8'h0A);
    wr(1, 8'h02);
    rd(1, 8'hFF, 8'h02);
    // interrupt pin and request gating
    I_PB_DRQ_REQ <= 1'b1;
    I_CAP_DRQ_REQ <= 1'b1;
    @(posedge I_CLK);
    I_PB_IRQ_EVENT <= 1'b1;
    @(posedge I_CLK);
    I_PB_IRQ_EVENT <= 1'b0;
    tick(2);
    chk("irq", 32'h1, {31'h0, O_IRQ});
    chk("playback drq", 32'h1, {31'h0, O_PB_DRQ});
    wr(0, 8'h2A);
    tick(1);
    chk("playback drq", 32'h0, {31'h0, O_PB_DRQ});
    chk("capture drq", 32'h1, {31'h0, O_CAP_DRQ});
    @(posedge I_CLK);
    I_CAP_IRQ_EVENT <= 1'b1;
    @(posedge I_CLK);
    I_CAP_IRQ_EVENT <= 1'b0;
    tick(1);
    chk("capture drq", 32'h0, {31'h0, O_CAP_DRQ});
    rd(2, 8'h01, 8'h01);
    wr(2, 8'h5A);
    tick(1);
    chk("irq", 32'h0, {31'h0, O_IRQ});
    chk("playback drq", 32'h1, {31'h0, O_PB_DRQ});
    chk("capture drq", 32'h1, {31'h0, O_CAP_DRQ});
    @(posedge I_CLK);
    I_OVERRUN <= 1'b1;
    @(posedge I_CLK);
    I_OVERRUN <= 1'b0;
    rd(2, 8'h10, 8'h10);
    // underrun sets the same error bit once it has been cleared
    wr(2, 8'h00);
    rd(2, 8'h10, 8'h00);
    @(posedge I_CLK);
    I_UNDERRUN <= 1'b1;
    @(posedge I_CLK);
    I_UNDERRUN <= 1'b0;
    rd(2, 8'h10, 8'h10);
    // playback: four bytes of a 16-bit stereo sample, a fifth is dropped
    rd(2, 8'h0C, 8'h04);
    smp = rnd();
    for (int i = 0; i < 4; i++) begin
      wr(3, smp[8*i +: 8]);
      if (i == 0) rd(2, 8'h0C, 8'h0C);
    end
    wr(3, ~smp[7:0]);
    tick(1);
    chk("playback sample", smp, O_PB_SAMPLE);
    rd(2, 8'h02, 8'h00);
    tick(12);
    chk("playback valid", 32'h0, {31'h0, O_PB_SAMPLE_VALID});
    rd(2, 8'h0E, 8'h06);
    // capture: status read plus new sample, then read past the last byte
    smp = rnd();
    fifo.push(smp);
    rd(2, 8'h00, 8'h00);
    tick(3);
    rd(2, 8'hE0, 8'h60);
    for (int i = 0; i < 5; i++) rd(3, 8'hFF, smp[8*(i > 3 ? 3 : i) +: 8]);
    rd(2, 8'h20, 8'h00);
    // dac rate codes
    foreach (codes[i]) begin
      I_DAC_RATE_CODE <= codes[i];
      tick(2);
      chk("divider", {20'h0, rdiv(codes[i])}, {20'h0, O_DAC_DIVIDER});
    end
    // mode one hides the upper bank even with the bank bit left set
    wr(0, 8'h1A);
    wr(1, 8'h77);
    rd(1, 8'hFF, 8'h77);
    I_MODE_EXT <= 1'b0;
    rd(1, 8'hFF, 8'h02);
    // soft power down blocks the port
    I_PM_FIELD <= 2'h1;
    wr(1, 8'h33);
    rd(0, 8'hFF, 8'h80);
    rd(1, 8'hFF, 8'h80);
    rd(3, 8'hFF, 8'h80);
    I_PM_FIELD <= 2'h0;
    rd(1, 8'hFF, 8'h02);
    tick(10);
    chk("pending answers", 32'h0, expq.size());
    results();
  end
endmodule : tb_cdrp_direct_port
